/* File: hw/level_ctl_cfg.svh */
// Constants of the automatic level control block: offsets, fields, resets, times.
// Assumes it is included by bare name from the design file, the checker and the bench.
`ifndef LEVEL_CTL_CFG_SVH
`define LEVEL_CTL_CFG_SVH

// Register word addresses on the plain register port.
`define ADDR_CFG_ONE 7'h20
`define ADDR_CFG_TWO 7'h21
`define ADDR_CFG_THREE 7'h22
`define ADDR_RATE 7'h24
`define ADDR_VOLUME 7'h2D
`define ADDR_STATUS 7'h2E

// Reset values.
`define RST_CFG_ONE 9'h038
`define RST_CFG_TWO 9'h00B
`define RST_CFG_THREE 9'h032
`define RST_RATE 3'h0
`define RST_GAIN 6'h10
`define RST_MUTE 1'b1

// Field positions.
`define SEL_BIT 8
`define CEIL_LSB 3
`define FLOOR_LSB 0
`define HOLD_LSB 4
`define TARGET_LSB 0
`define MODE_BIT 8
`define DECAY_LSB 4
`define ATTACK_LSB 0
`define MUTE_BIT 6

// Gain scale: 0.75 dB per step, eight steps per 6 dB, code 0 is the floor of the range.
`define STEPS_6DB 6'h08
`define CEIL_OFFSET 6'h07
`define MAX_RATE_CODE 4'hA
`define TARGET_TOP 6'h0F
`define TRIM_SHIFT 7

// Per-step times in ns, clock in MHz, and cycle counts derived from them (rounded up).
`define CLK_MHZ 25
`define ATK_NORM_NS 104000
`define DCY_NORM_NS 410000
`define ATK_LIM_NS 22700
`define DCY_LIM_NS 90800
`define HOLD_NS 2670000
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)

`endif

/* File: hw/level_ctl_pkg.sv */
// Types shared by the automatic level control design files.
// Assumes nothing of its surroundings.
package level_ctl_pkg;
    // Phase of the gain loop.
    typedef enum {PH_IDLE, PH_ATTACK, PH_HOLD, PH_DECAY} phase_type;
endpackage

/* File: hw/step_timer_if.sv */
// Interface between the loop and one interval timer.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface step_timer_if;
    logic [26:0] interval; // Interval length in clock cycles.
    logic restart;         // Holds the count at zero.
    logic expired;         // One-cycle pulse at the end of each interval.
    modport owner(output interval, output restart, input expired);
    modport timer(input interval, input restart, output expired);
endinterface
`default_nettype wire

/* File: hw/step_timer.sv */
// Free-running interval timer that pulses once per programmed interval.
// Assumes the interval is at least one cycle and steady while counting.
`timescale 1ns/1ps
`default_nettype none
module step_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Owner side.
    step_timer_if.timer tmr
);
    logic [26:0] count; // Cycles elapsed in the current interval.

    // The pulse is combinational so the owner sees it in the last cycle of the interval.
    assign tmr.expired = !tmr.restart && (count >= tmr.interval - 27'h1);

    // Count up, wrap at the interval end, hold at zero while restarted.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= 27'h0;
        end else if (tmr.restart || tmr.expired) begin
            count <= 27'h0;
        end else begin
            count <= count + 27'h1;
        end
    end
endmodule
`default_nettype wire

/* File: hw/automatic_level_control.sv */
// Automatic level control loop steering the input amplifier gain.
// Assumes a level measurement that is synchronous to clk and a plain register port.
//
// Operation
// - Disabled loop keeps gain; only software writes.
// - Normal mode tracks the target level.
// - Limiter only reduces peaks, never exceeds start unless start is below the floor.
// - Start gain latched on entering limiter.
// - Attack paces reductions, decay paces increases.
// - Normal attack 104us per step, doubling.
// - Normal decay 410us per step, doubling.
// - Limiter attack 22.7us per step, doubling.
// - Limiter decay 90.8us per step, doubling.
// - Step intervals depend on sample rate setting.
// - Ceiling and floor act only under loop.
// - Ceiling code 111 is 35.25 dB, 6 dB steps.
// - Floor code 000 is -12 dB, 6 dB steps.
// - Limiter ceiling is the lower of the latched start gain and the ceiling.
// - Out-of-range gain returns to range at once.
// - Normal mode waits hold time before decay.
// - Hold expiry below target starts decay.
// - Rising above target abandons the hold.
// - Hold 2.67ms at code 0001, doubling.
// - Target code sets level in 1.5 dB steps.
`timescale 1ns/1ps
`include "level_ctl_cfg.svh"
`default_nettype none
module automatic_level_control #(
    parameter int ATK_NORM_CYC = `NS_TO_CYC(`ATK_NORM_NS),
    parameter int DCY_NORM_CYC = `NS_TO_CYC(`DCY_NORM_NS),
    parameter int ATK_LIM_CYC = `NS_TO_CYC(`ATK_LIM_NS),
    parameter int DCY_LIM_CYC = `NS_TO_CYC(`DCY_LIM_NS),
    parameter int HOLD_CYC = `NS_TO_CYC(`HOLD_NS)
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Register port.
    input wire logic [6:0] addr,
    input wire logic [8:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [8:0] rdata,
    // Level measured at the converter input, in 1.5 dB steps below full scale.
    input wire logic [5:0] level_atten,
    // Amplifier gain control.
    output logic [5:0] input_gain_volume,
    output logic input_gain_mute
);
    // ****************************************
    // Register storage
    // ****************************************

    logic [8:0] cfg_one;   // Select, ceiling and floor codes.
    logic [8:0] cfg_two;   // Hold and target codes.
    logic [8:0] cfg_three; // Mode, decay and attack codes.
    logic [2:0] sample_rate_select; // Sample rate setting that trims step intervals.

    // Decoded fields.
    logic level_ctl_select;
    logic level_ctl_mode_select;
    logic [2:0] gain_ceiling_code;
    logic [2:0] gain_floor_code;
    logic [3:0] hold_time_code;
    logic [3:0] target_level_code;
    logic [3:0] attack_rate_code;
    logic [3:0] decay_rate_code;

    assign level_ctl_select = cfg_one[`SEL_BIT];
    assign gain_ceiling_code = cfg_one[`CEIL_LSB +: 3];
    assign gain_floor_code = cfg_one[`FLOOR_LSB +: 3];
    assign hold_time_code = cfg_two[`HOLD_LSB +: 4];
    assign target_level_code = cfg_two[`TARGET_LSB +: 4];
    assign level_ctl_mode_select = cfg_three[`MODE_BIT];
    assign decay_rate_code = cfg_three[`DECAY_LSB +: 4];
    assign attack_rate_code = cfg_three[`ATTACK_LSB +: 4];

    // Write strobes, one per register.
    logic wr_one;
    logic wr_two;
    logic wr_three;
    logic wr_rate;
    logic wr_volume;

    assign wr_one = wr && (addr == `ADDR_CFG_ONE);
    assign wr_two = wr && (addr == `ADDR_CFG_TWO);
    assign wr_three = wr && (addr == `ADDR_CFG_THREE);
    assign wr_rate = wr && (addr == `ADDR_RATE);
    assign wr_volume = wr && (addr == `ADDR_VOLUME);

    // Configuration registers take a write in the cycle of the strobe.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_one <= `RST_CFG_ONE;
            cfg_two <= `RST_CFG_TWO;
            cfg_three <= `RST_CFG_THREE;
            sample_rate_select <= `RST_RATE;
        end else begin
            if (wr_one) begin
                cfg_one <= wdata & 9'h13F;
            end
            if (wr_two) begin
                cfg_two <= wdata & 9'h0FF;
            end
            if (wr_three) begin
                cfg_three <= wdata;
            end
            if (wr_rate) begin
                sample_rate_select <= wdata[2:0];
            end
        end
    end

    // The mute bit belongs to software alone; the loop never touches it.
    // Software is expected to clear it before selecting the loop.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            input_gain_mute <= `RST_MUTE;
        end else if (wr_volume) begin
            input_gain_mute <= wdata[`MUTE_BIT];
        end
    end

    // ****************************************
    // Gain limits
    // ****************************************

    logic [5:0] ceil_idx;   // Programmed ceiling as a gain index.
    logic [5:0] floor_idx;  // Programmed floor as a gain index.
    logic [5:0] start_gain; // Gain latched on entry to limiter mode.
    logic [5:0] eff_ceil;   // Ceiling that actually applies.

    // Ceiling 111 lands on index 63 (35.25 dB), each code below 6 dB lower.
    assign ceil_idx = 6'(gain_ceiling_code * `STEPS_6DB) + `CEIL_OFFSET;
    // Floor 000 lands on index 0 (-12 dB), each code above 6 dB higher.
    assign floor_idx = 6'(gain_floor_code * `STEPS_6DB);
    logic sel_q;  // Select bit one cycle ago.
    logic mode_q; // Mode bit one cycle ago.

    // Track select and mode so that the entry into limiter mode can be seen.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            sel_q <= level_ctl_select;
            mode_q <= level_ctl_mode_select;
        end
    end

    logic lim_entry;        // The loop enters limiter mode in this cycle.
    logic [5:0] live_start; // Start gain that applies now, fresh in the entry cycle.

    assign lim_entry = level_ctl_select && level_ctl_mode_select && (!sel_q || !mode_q);
    // In the entry cycle the register still holds a stale value, so the live gain is used.
    assign live_start = lim_entry ? input_gain_volume : start_gain;

    // Latch the start gain when the loop starts in limiter mode or switches to it.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_gain <= `RST_GAIN;
        end else if (lim_entry) begin
            start_gain <= input_gain_volume;
        end
    end

    // In limiter mode the start gain caps the ceiling unless the programmed one is lower.
    assign eff_ceil = (level_ctl_mode_select && (live_start < ceil_idx)) ? live_start : ceil_idx;

    // ****************************************
    // Level comparison
    // ****************************************

    logic [5:0] target_atten; // Target level in 1.5 dB steps below full scale.
    logic above;              // Level is louder than the target.
    logic below;              // Level is quieter than the target.

    // Codes 1111 and 1110 both mean -1.5 dBFS; below that 1.5 dB per code.
    assign target_atten = (target_level_code == 4'hF) ? 6'h01 : `TARGET_TOP - {2'h0, target_level_code};
    assign above = level_atten < target_atten;
    assign below = level_atten > target_atten;

    // ****************************************
    // Phase machine
    // ****************************************

    level_ctl_pkg::phase_type phase;      // Present phase.
    level_ctl_pkg::phase_type next_phase; // Phase for the next cycle.

    step_timer_if step_if(); // Paces single gain steps.
    step_timer_if hold_if(); // Measures the hold time.

    // Choose the next phase from the level, the mode and the hold timer.
    always_comb begin
        next_phase = level_ctl_pkg::PH_IDLE;
        if (!level_ctl_select) begin
            next_phase = level_ctl_pkg::PH_IDLE;
        end else if (above) begin
            // Loud peaks always pull the gain down, in both modes.
            next_phase = level_ctl_pkg::PH_ATTACK;
        end else if (level_ctl_mode_select) begin
            // The limiter only recovers towards its start gain and has no hold.
            if (input_gain_volume < eff_ceil) begin
                next_phase = level_ctl_pkg::PH_DECAY;
            end
        end else if (below) begin
            case (phase)
                level_ctl_pkg::PH_HOLD: begin
                    // A quiet level that outlasts the hold is the new average.
                    next_phase = hold_if.expired ? level_ctl_pkg::PH_DECAY : level_ctl_pkg::PH_HOLD;
                end
                level_ctl_pkg::PH_DECAY: begin
                    next_phase = level_ctl_pkg::PH_DECAY;
                end
                default: begin
                    // Wait out the hold before raising gain; code zero skips it.
                    next_phase = (hold_time_code == 4'h0) ? level_ctl_pkg::PH_DECAY : level_ctl_pkg::PH_HOLD;
                end
            endcase
        end
        // In normal mode a level at target leaves the gain alone, and a louder one during hold leaves it.
    end

    // Register the phase.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase <= level_ctl_pkg::PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // ****************************************
    // Step intervals
    // ****************************************

    // Double a base interval per code step, saturating at code 1010.
    function automatic logic [26:0] scale(input logic [26:0] base, input logic [3:0] code);
        logic [3:0] c;
        c = (code > `MAX_RATE_CODE) ? `MAX_RATE_CODE : code;
        scale = base << c;
    endfunction

    // Lengthen an interval slightly per sample rate setting, as the real clocks differ.
    function automatic logic [26:0] trim(input logic [26:0] raw, input logic [2:0] rate);
        logic [26:0] unit;
        unit = raw >> `TRIM_SHIFT;
        trim = raw + 27'(unit * {24'h0, rate});
    endfunction

    logic [26:0] atk_base;  // Attack base interval for the present mode.
    logic [26:0] dcy_base;  // Decay base interval for the present mode.
    logic [26:0] hold_len;  // Hold interval for the present code.

    // Limiter steps are faster than normal steps.
    assign atk_base = level_ctl_mode_select ? 27'(ATK_LIM_CYC) : 27'(ATK_NORM_CYC);
    assign dcy_base = level_ctl_mode_select ? 27'(DCY_LIM_CYC) : 27'(DCY_NORM_CYC);
    // Code 0001 gives the base hold, each higher code doubles it.
    // Codes above 1010 keep the longest hold rather than doubling once more.
    assign hold_len = scale(27'(HOLD_CYC),
        ((hold_time_code > `MAX_RATE_CODE) ? `MAX_RATE_CODE : hold_time_code) - 4'h1);

    // Reductions use the attack code and increases the decay code.
    assign step_if.interval = (next_phase == level_ctl_pkg::PH_ATTACK) ?
        trim(scale(atk_base, attack_rate_code), sample_rate_select) :
        trim(scale(dcy_base, decay_rate_code), sample_rate_select);
    // A new phase starts a fresh interval so that the first step takes a whole one.
    assign step_if.restart = (next_phase != phase) || !level_ctl_select;

    // The hold timer runs only while the loop holds.
    assign hold_if.interval = trim(hold_len, sample_rate_select);
    assign hold_if.restart = (phase != level_ctl_pkg::PH_HOLD);

    step_timer step_timer_inst (
        .clk(clk),
        .rst_b(rst_b),
        .tmr(step_if.timer)
    );

    step_timer hold_timer_inst (
        .clk(clk),
        .rst_b(rst_b),
        .tmr(hold_if.timer)
    );

    // ****************************************
    // Gain register
    // ****************************************

    logic step_fire; // One gain step is due in the present phase.

    assign step_fire = step_if.expired &&
        ((phase == level_ctl_pkg::PH_ATTACK) || (phase == level_ctl_pkg::PH_DECAY));

    // Software owns the gain while the loop is off; the loop owns it while on.
    // The floor wins over the ceiling if software sets them crossed, which avoids a
    // gain that flips between the two limits every cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            input_gain_volume <= `RST_GAIN;
        end else if (!level_ctl_select) begin
            // Off: the last loop value stays, limits do not apply.
            if (wr_volume) begin
                input_gain_volume <= wdata[5:0];
            end
        end else if (input_gain_volume < floor_idx) begin
            input_gain_volume <= floor_idx;
        end else if ((input_gain_volume > eff_ceil) && (eff_ceil >= floor_idx)) begin
            input_gain_volume <= eff_ceil;
        end else if (step_fire) begin
            // One step per interval, never past the active limits.
            if ((phase == level_ctl_pkg::PH_ATTACK) && (input_gain_volume > floor_idx)) begin
                input_gain_volume <= input_gain_volume - 6'h01;
            end else if ((phase == level_ctl_pkg::PH_DECAY) && (input_gain_volume < eff_ceil)) begin
                input_gain_volume <= input_gain_volume + 6'h01;
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************

    // Read data stand for exactly one cycle after the strobe and are zero otherwise.
    // The volume register reads back the live gain so software can watch the loop.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 9'h000;
        end else if (rd) begin
            case (addr)
                `ADDR_CFG_ONE: begin
                    rdata <= cfg_one;
                end
                `ADDR_CFG_TWO: begin
                    rdata <= cfg_two;
                end
                `ADDR_CFG_THREE: begin
                    rdata <= cfg_three;
                end
                `ADDR_RATE: begin
                    rdata <= {6'h00, sample_rate_select};
                end
                `ADDR_VOLUME: begin
                    rdata <= {2'h0, input_gain_mute, input_gain_volume};
                end
                `ADDR_STATUS: begin
                    rdata <= {1'b0, 2'(phase), input_gain_volume};
                end
                default: begin
                    rdata <= 9'h000;
                end
            endcase
        end else begin
            rdata <= 9'h000;
        end
    end
endmodule
`default_nettype wire

/* File: tb/level_ctl_sva.sv */
// Port checker for the automatic level control block.
// Assumes it is bound to automatic_level_control with its two normal-mode counts.
`timescale 1ns/1ps
`include "level_ctl_cfg.svh"
`default_nettype none
module level_ctl_sva #(
    parameter int ATK_NORM_CYC = 8,
    parameter int DCY_NORM_CYC = 16
) (
    // Clock, reset and register port.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] addr,
    input wire logic [8:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [8:0] rdata,
    // Level and gain.
    input wire logic [5:0] level_atten,
    input wire logic [5:0] input_gain_volume,
    input wire logic input_gain_mute
);
    // ********************
    // Shadow state
    // ********************
    logic sel_q, mode_q, run_q, lim_d;
    logic [2:0] ceil_q, floor_q;
    logic [5:0] gain_d, start_q, wd_q;
    logic [15:0] gap; // Cycles since the gain last moved.
    wire logic vol_wr = wr && addr == `ADDR_VOLUME;
    wire logic lim_on = sel_q && mode_q;

    // Shadow of the loop settings, taken from writes.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_q <= 1'b0;
            mode_q <= 1'b0;
            ceil_q <= 3'h7;
            floor_q <= 3'h0;
        end else if (wr && addr == `ADDR_CFG_ONE) begin
            sel_q <= wdata[8];
            ceil_q <= wdata[5:3];
            floor_q <= wdata[2:0];
        end else if (wr && addr == `ADDR_CFG_THREE) begin
            mode_q <= wdata[8];
        end
    end

    // Gain history; run_q drops for one cycle after any limit or mode write.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gain_d <= 6'h10;
            gap <= 16'h0000;
            run_q <= 1'b0;
            lim_d <= 1'b0;
            start_q <= 6'h10;
            wd_q <= 6'h00;
        end else begin
            gain_d <= input_gain_volume;
            gap <= (input_gain_volume != gain_d) ? 16'h0001 : gap + {15'h0000, gap != 16'hFFFF};
            run_q <= sel_q && !(wr && (addr == `ADDR_CFG_ONE || addr == `ADDR_CFG_THREE));
            lim_d <= lim_on;
            start_q <= (lim_on && !lim_d) ? input_gain_volume : start_q;
            wd_q <= wdata[5:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ********************
    // Assertions
    // ********************
    AST_OFF_FROZEN: assert property (!sel_q && !vol_wr |=> $stable(input_gain_volume))
        else $error("gain moved while the loop is off");
    AST_VOL_WRITE: assert property (vol_wr && !sel_q |=> input_gain_volume == wd_q)
        else $error("gain write not applied");
    AST_MUTE_SW: assert property (!vol_wr |=> $stable(input_gain_mute))
        else $error("mute changed without a write");
    AST_FLOOR: assert property (run_q |-> input_gain_volume >= {floor_q, 3'h0})
        else $error("gain below floor");
    AST_CEIL: assert property (run_q && floor_q <= ceil_q |-> input_gain_volume <= {ceil_q, 3'h7})
        else $error("gain above ceiling");
    AST_ONE_STEP: assert property (run_q && $past(run_q) |-> input_gain_volume == gain_d ||
        input_gain_volume == gain_d + 6'h01 || input_gain_volume == gain_d - 6'h01)
        else $error("gain moved by more than one step");
    AST_ATTACK_GAP: assert property (run_q && $past(run_q) && !mode_q &&
        input_gain_volume == gain_d - 6'h01 |-> gap >= ATK_NORM_CYC)
        else $error("attack step too early");
    AST_DECAY_GAP: assert property (run_q && $past(run_q) && !mode_q &&
        input_gain_volume == gain_d + 6'h01 |-> gap >= DCY_NORM_CYC)
        else $error("decay step too early");
    AST_LIM_CAP: assert property (run_q && $past(run_q) && lim_d &&
        start_q >= {floor_q, 3'h0} |-> input_gain_volume <= start_q)
        else $error("limiter raised gain above start");

    cover property (run_q && input_gain_volume == gain_d - 6'h01);
    cover property (run_q && input_gain_volume == gain_d + 6'h01);
    cover property (run_q && lim_d);
endmodule
`default_nettype wire

/* File: tb/gain_path_model.sv */
// Model of the amplifier and converter level path feeding the loop.
// Assumes src_q is the source level below full scale at 0 dB gain, 0.75 dB units.
`timescale 1ns/1ps
`default_nettype none
module gain_path_model (
    // Clock.
    input wire logic clk,
    // Source and gain.
    input wire logic [6:0] src_q,
    input wire logic [5:0] input_gain_volume,
    // Measured level.
    output logic [5:0] level_atten
);
    int adc; // Converter level in 0.75 dB steps; gain index 16 is 0 dB.

    // Gain lowers the attenuation seen at the converter.
    always_comb begin
        adc = int'(src_q) + 16 - int'(input_gain_volume);
    end

    // One cycle of converter delay; level saturates at both ends.
    always_ff @(posedge clk) begin
        level_atten <= (adc < 0) ? 6'h00 : (adc > 127) ? 6'h3F : 6'(adc / 2);
    end
endmodule
`default_nettype wire

/* File: tb/automatic_level_control_bench.sv */
// Self-checking bench of the automatic level control block.
// Assumes the level path model and the port checker bound below.
`timescale 1ns/1ps
`include "level_ctl_cfg.svh"
`default_nettype none
module automatic_level_control_bench;
    logic clk, rst_b, wr, rd;
    logic [6:0] addr, src_q;
    logic [8:0] wdata, rdata;
    logic [5:0] level_atten, input_gain_volume;
    logic input_gain_mute;
    int num_errors, checks;
    logic [24:0] rows [7]; // Address, write data, read back.
    logic [15:0] rvals [6]; // Address, reset value.

    automatic_level_control #(.ATK_NORM_CYC(8), .DCY_NORM_CYC(16), .ATK_LIM_CYC(4),
        .DCY_LIM_CYC(8), .HOLD_CYC(32)) automatic_level_control_i (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .level_atten(level_atten),
        .input_gain_volume(input_gain_volume), .input_gain_mute(input_gain_mute));
    gain_path_model gain_path_model_i (.clk(clk), .src_q(src_q),
        .input_gain_volume(input_gain_volume), .level_atten(level_atten));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    // Waits n edges, then compares the gain once settled.
    task automatic gain_chk(input int n, input logic [5:0] exp);
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk({3'h0, input_gain_volume}, {3'h0, exp});
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need under 3000 cycles.
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    initial begin
        rows = '{{7'h20, 9'h0F8, 9'h038}, {7'h21, 9'h1AB, 9'h0AB}, {7'h22, 9'h1FF, 9'h1FF},
            {7'h24, 9'h1FF, 9'h007}, {7'h30, 9'h1FF, 9'h000}, {7'h2D, 9'h1DA, 9'h05A},
            {7'h2E, 9'h1FF, 9'h01A}};
        rvals = '{{7'h20, 9'h038}, {7'h21, 9'h00B}, {7'h22, 9'h032}, {7'h24, 9'h000},
            {7'h2D, 9'h050}, {7'h2E, 9'h010}};
        num_errors = 0;
        checks = 0;
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 7'h00;
        wdata = 9'h000;
        src_q = 7'h00;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        // Register rows: reserved bits, read-only status and an unmapped place.
        for (int i = 0; i < 7; i++) begin
            wr_reg(rows[i][24:18], rows[i][17:9]);
            rd_chk(rows[i][24:18], rows[i][8:0]);
        end
        // Normal mode: loud source is pulled down to target, quiet one up.
        wr_reg(7'h2D, 9'h010);
        wr_reg(7'h21, 9'h00B);
        wr_reg(7'h22, 9'h000);
        wr_reg(7'h20, 9'h138);
        gain_chk(150, 6'h08);
        src_q <= 7'h14;
        gain_chk(450, 6'h1B);
        // Limits changed in operation pull the gain back at once.
        wr_reg(7'h20, 9'h110);
        gain_chk(3, 6'h17);
        wr_reg(7'h20, 9'h13C);
        gain_chk(3, 6'h20);
        gain_chk(40, 6'h20);
        // Hold before decay, then decay to the ceiling.
        wr_reg(7'h21, 9'h01B);
        src_q <= 7'h3C;
        gain_chk(10, 6'h20);
        rd_chk(7'h2E, 9'h0A0);
        // A loud burst during the hold abandons it; the hold restarts in full afterwards.
        src_q <= 7'h00;
        gain_chk(2, 6'h20);
        rd_chk(7'h2E, 9'h060);
        src_q <= 7'h3C;
        gain_chk(55, 6'h21);
        gain_chk(600, 6'h3F);
        // Loop off: gain frozen, limits ignored, software write applies.
        wr_reg(7'h20, 9'h03C);
        src_q <= 7'h00;
        gain_chk(100, 6'h3F);
        wr_reg(7'h2D, 9'h003);
        gain_chk(1, 6'h03);
        // Limiter: never above the start gain, faster steps.
        wr_reg(7'h2D, 9'h014);
        src_q <= 7'h14;
        wr_reg(7'h22, 9'h100);
        wr_reg(7'h20, 9'h138);
        gain_chk(2, 6'h14);
        gain_chk(50, 6'h14);
        src_q <= 7'h00;
        gain_chk(100, 6'h08);
        src_q <= 7'h14;
        gain_chk(200, 6'h14);
        wr_reg(7'h2D, 9'h040);
        rd_chk(7'h2D, 9'h054);
        chk({8'h00, input_gain_mute}, 9'h001);
        // Second reset restores every register.
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rvals[i]) begin
            rd_chk(rvals[i][15:9], rvals[i][8:0]);
        end
        finish_test();
    end
endmodule

bind automatic_level_control level_ctl_sva #(.ATK_NORM_CYC(ATK_NORM_CYC), .DCY_NORM_CYC(DCY_NORM_CYC))
    level_ctl_sva_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .level_atten(level_atten), .input_gain_volume(input_gain_volume),
    .input_gain_mute(input_gain_mute));
`default_nettype wire
